// file: rtl/pfac_regs.svh
// register offsets, control bit positions, reset values and timing counts
`ifndef PFAC_REGS_SVH
`define PFAC_REGS_SVH
// register byte offsets on the apb bus
`define PFAC_OFS_CTRL 12'h000
`define PFAC_OFS_KEY 12'h004
`define PFAC_OFS_ADRL 12'h008
`define PFAC_OFS_ADRH 12'h00c
`define PFAC_OFS_DATL 12'h010
`define PFAC_OFS_DATH 12'h014
// flash_control_reg bit positions
`define PFAC_CTRL_RD 0
`define PFAC_CTRL_WR 1
`define PFAC_CTRL_WRITE_ENABLE_GATE 2
`define PFAC_CTRL_ERASE 3
`define PFAC_CTRL_LATCH_ONLY_SELECT 4
`define PFAC_CTRL_SPACE 5
`define PFAC_CTRL_FLAG 6
`define PFAC_CTRL_IE 7
// reset and fill values
`define PFAC_CTRL_RST 8'h00
`define PFAC_ERASED 14'h3fff
`define PFAC_KEY1 8'h55
`define PFAC_KEY2 8'haa
// indirect window base bit: pointer bit 15 selects flash
`define PFAC_IND_WIN 15
// timing: times in ns, counts rounded up to whole 40 ns cycles
`define PFAC_CLK_NS 40
`define PFAC_ERASE_NS 20000
`define PFAC_PROG_NS 20000
`define PFAC_ERASE_CYC ((`PFAC_ERASE_NS + `PFAC_CLK_NS - 1) / `PFAC_CLK_NS)
`define PFAC_PROG_CYC ((`PFAC_PROG_NS + `PFAC_CLK_NS - 1) / `PFAC_CLK_NS)
`define PFAC_LOAD_CYC 1
`endif

// file: rtl/pfac_pkg.sv
// types shared by the flash access control block
package pfac_pkg;
	// unlock sequence progress
	typedef enum logic [1:0] {UL_IDLE, UL_KEY1, UL_KEY2} pfac_unlock_t;
	// operation in flight
	typedef enum logic [1:0] {OP_NONE, OP_ERASE, OP_LOAD, OP_PROG} pfac_op_t;
	// apb request from the master
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} pfac_apb_req_t;
	// apb answer to the master
	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} pfac_apb_rsp_t;
	// indirect pointer read request
	typedef struct packed {
		logic valid;
		logic [15:0] addr;
	} pfac_ind_req_t;
endpackage

// file: rtl/pfac_flash_array.sv
// program flash array with row erase, and-only row program, two read ports
`timescale 1ns/10ps
`default_nettype none
module pfac_flash_array #(
	parameter int WORDS = 2048,
	parameter int ROW = 32,
	parameter int W = 14,
	localparam int AW = $clog2(WORDS),
	localparam int RW = $clog2(WORDS / ROW)
) (
	input wire logic clk, // flash clock
	input wire logic erase_en, // clear one row to ones
	input wire logic prog_en, // program latches into one row
	input wire logic [RW-1:0] row, // row for erase or program
	input wire logic [ROW*W-1:0] latch_data, // latch contents, word 0 low
	input wire logic [AW-1:0] rd_a_addr, // indirect read address
	output logic [W-1:0] rd_a_data, // indirect read word
	input wire logic [AW-1:0] rd_b_addr, // register read address
	output logic [W-1:0] rd_b_data // register read word
);
	// cells; no reset, like a real array contents survive reset
	logic [W-1:0] mem [WORDS];

	// async reads so a fetch finishes in a single cycle
	assign rd_a_data = mem[rd_a_addr];
	assign rd_b_data = mem[rd_b_addr];

	// erase drives a row to ones, program can only pull bits to zero
	always_ff @(posedge clk) begin
		for (int i = 0; i < ROW; i++) begin
			if (erase_en) begin
				mem[{row, i[AW-RW-1:0]}] <= {W{1'b1}};
			end else if (prog_en) begin
				mem[{row, i[AW-RW-1:0]}] <= mem[{row, i[AW-RW-1:0]}] & latch_data[i*W +: W];
			end
		end
	end
endmodule // pfac_flash_array
`default_nettype wire

// file: rtl/pfac_top.sv
// flash access control: apb register set, unlock, erase, latch load, program
//
// What this block does
// - words are 14 bits, erase ones, program zeros
// - rows of 32 words, row is erase unit
// - hidden 14-bit latches filled via data pair
// - row erase and writes only, no bulk
// - indirect read takes one cycle, one byte
// - indirect path never writes the array
// - ids and config read only, user ids writable
// - write protection blocks every write and erase
// - space bit picks flash or id space
// - read strobe stalls, data next cycle, self-clears
// - data pair holds until next read or write
// - erase, load, program need full unlock first
// - unlock is 55h, then AAh, then strobe
// - unlock steps back to back, gaps abort
// - strobe stalls cpu until operation finishes
// - protected erase clears strobe, row untouched
// - erase stalls cpu, then flag and interrupt
// - erase keeps latches and enable bit
// - program never erases on its own
// - high bits pick row, low five pick latch
// - latches return to 3fffh after programming
// - latch-only set loads, clear programs row
`include "pfac_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module pfac_top import pfac_pkg::*; #(
	parameter int WORDS = 2048, // program flash words
	parameter int ROW = 32, // words per row and write latches
	parameter int UIDS = 4, // user id words
	parameter int ERASE_CYCLES = `PFAC_ERASE_CYC, // row erase stall
	parameter int PROG_CYCLES = `PFAC_PROG_CYC, // row program stall
	parameter logic [13:0] REV_ID = 14'h0123, // arbitrary value
	parameter logic [13:0] DEV_ID = 14'h0abc, // arbitrary value
	parameter logic [13:0] CFG_WORD = `PFAC_ERASED // configuration words
) (
	input wire logic pclk, // clock
	input wire logic presetn, // async reset, active low
	input wire pfac_apb_req_t apb_i, // apb request
	output pfac_apb_rsp_t apb_o, // apb answer
	input wire pfac_ind_req_t ind_i, // indirect pointer read
	output logic [7:0] ind_data_o, // indirect read byte
	output logic ind_valid_o, // indirect byte valid
	input wire logic write_protect, // device write protected
	output logic cpu_stall_o, // cpu suspended
	output logic done_irq_o // completion interrupt
);
	localparam int W = 14;
	localparam int AW = $clog2(WORDS);
	localparam int RW = $clog2(WORDS / ROW);
	localparam int LW = $clog2(ROW);

	// refuse shapes the address split cannot serve
	if (ROW != 32 || WORDS % ROW != 0 || WORDS > 32768 || UIDS > ROW) begin : g_bad_shape
		$error("pfac_top: unsupported array shape");
	end
	if (ERASE_CYCLES < 1 || PROG_CYCLES < 1 || ERASE_CYCLES > 65535 || PROG_CYCLES > 65535)
	begin : g_bad_time
		$error("pfac_top: operation time out of range");
	end

	// whole state of the block
	typedef struct packed {
		pfac_unlock_t ul; // unlock progress
		pfac_op_t op; // operation, kept until its stalled transfer completes
		logic busy; // operation in flight
		logic [15:0] cnt; // cycles left
		logic [7:0] ctrl; // flash_control_reg
		logic [14:0] addr; // flash_addr_high:flash_addr_low
		logic [W-1:0] data; // flash_data_high:flash_data_low
		logic [ROW-1:0][W-1:0] latch; // write latches
		logic [UIDS-1:0][W-1:0] uid; // user id words
		logic pready; // apb ready
		logic pslverr; // apb error
		logic [31:0] prdata; // apb read data
		logic [7:0] ind_data; // indirect byte
		logic ind_valid; // indirect byte valid
		logic stall; // cpu stall
		logic irq; // interrupt line
	} pfac_state_t;

	pfac_state_t q, d; // registered state and next value
	logic setup; // apb setup cycle
	logic access; // apb access completing this edge
	logic finish; // operation ends this edge
	logic start; // unlocked strobe in this setup cycle
	logic allowed; // target may be changed
	logic arr_erase; // array row erase strobe
	logic arr_prog; // array row program strobe
	logic [W-1:0] arr_a; // indirect word
	logic [W-1:0] arr_b; // register read word
	logic [W-1:0] rd_word; // word for a register read
	logic [W-1:0] ind_word; // word for an indirect read
	logic [ROW*W-1:0] latch_flat; // latches flattened for the array
	logic in_pfm; // address falls inside flash
	logic [3:0] cfg_idx; // id space index

	assign latch_flat = q.latch;
	assign in_pfm = (q.addr < 15'(WORDS));
	assign cfg_idx = q.addr[3:0];

	pfac_flash_array #(
		.WORDS(WORDS),
		.ROW(ROW),
		.W(W)
	) u_array (
		.clk(pclk),
		.erase_en(arr_erase),
		.prog_en(arr_prog),
		.row(q.addr[AW-1:LW]),
		.latch_data(latch_flat),
		.rd_a_addr(ind_i.addr[AW-1:0]),
		.rd_a_data(arr_a),
		.rd_b_addr(q.addr[AW-1:0]),
		.rd_b_data(arr_b)
	);

	// register read source; space bit steers flash or id space
	always_comb begin
		rd_word = '0;
		if (!q.ctrl[`PFAC_CTRL_SPACE]) begin
			rd_word = in_pfm ? arr_b : `PFAC_ERASED;
		end else if (q.addr[14:4] != '0) begin
			rd_word = '0; // outside id space reads zero
		end else if (32'(cfg_idx) < UIDS) begin
			rd_word = q.uid[cfg_idx[$clog2(UIDS)-1:0]];
		end else if (cfg_idx == 4'h5) begin
			rd_word = REV_ID;
		end else if (cfg_idx == 4'h6) begin
			rd_word = DEV_ID;
		end else if (cfg_idx >= 4'h7 && cfg_idx <= 4'hb) begin
			rd_word = CFG_WORD;
		end else begin
			rd_word = '0; // reserved slot
		end
	end

	// indirect read source: only the flash window answers
	always_comb begin
		ind_word = '0;
		if (ind_i.addr[`PFAC_IND_WIN] && ind_i.addr[14:0] < 15'(WORDS)) begin
			ind_word = arr_a;
		end
	end

	// may the current target be changed at all
	always_comb begin
		allowed = 1'b0;
		if (!write_protect) begin
			// only user ids writable in id space
			if (q.ctrl[`PFAC_CTRL_SPACE]) begin
				allowed = (q.addr[14:LW] == '0);
			end else begin
				allowed = in_pfm;
			end
		end
	end

	// strobe decode in the setup cycle, so the stall starts on time
	always_comb begin
		setup = apb_i.psel && !apb_i.penable;
		access = apb_i.psel && apb_i.penable && q.pready;
		// start only out of a full unlock
		// enable bit must already be set
		start = setup && !q.busy && apb_i.pwrite && q.ul == UL_KEY2
			&& apb_i.paddr == `PFAC_OFS_CTRL && apb_i.pwdata[`PFAC_CTRL_WR]
			&& q.ctrl[`PFAC_CTRL_WRITE_ENABLE_GATE] && allowed;
		finish = q.busy && q.cnt == '0;
	end

	// array strobes fire on the finishing edge with live latches
	always_comb begin
		arr_erase = 1'b0;
		arr_prog = 1'b0;
		if (finish && !q.ctrl[`PFAC_CTRL_SPACE]) begin
			// erase only ever clears one row
			arr_erase = (q.op == OP_ERASE);
			arr_prog = (q.op == OP_PROG);
		end
	end

	// next state
	always_comb begin
		d = q;
		d.pready = 1'b0;
		d.pslverr = 1'b0;
		d.ind_valid = 1'b0;
		if (ind_i.valid) begin
			d.ind_valid = 1'b1;
			d.ind_data = ind_word[7:0];
		end
		// operation countdown
		if (q.busy && q.cnt != '0) begin
			d.cnt = q.cnt - 16'd1;
		end
		// setup cycle: answer at once unless an operation starts
		if (setup && !q.busy) begin
			if (start) begin
				d.busy = 1'b1;
				d.ctrl[`PFAC_CTRL_WR] = 1'b1;
				if (q.ctrl[`PFAC_CTRL_ERASE]) begin
					d.op = OP_ERASE;
					d.cnt = 16'(ERASE_CYCLES - 1);
				end else if (q.ctrl[`PFAC_CTRL_LATCH_ONLY_SELECT]) begin
					d.op = OP_LOAD;
					d.cnt = 16'(`PFAC_LOAD_CYC - 1);
				end else begin
					d.op = OP_PROG;
					d.cnt = 16'(PROG_CYCLES - 1);
				end
			end else begin
				d.pready = 1'b1;
				// read data and error must stand together with ready
				case (apb_i.paddr)
					`PFAC_OFS_CTRL: d.prdata = {24'h000000, q.ctrl};
					`PFAC_OFS_KEY: d.prdata = '0;
					`PFAC_OFS_ADRL: d.prdata = {24'h000000, q.addr[7:0]};
					`PFAC_OFS_ADRH: d.prdata = {25'h0000000, q.addr[14:8]};
					`PFAC_OFS_DATL: d.prdata = {24'h000000, q.data[7:0]};
					`PFAC_OFS_DATH: d.prdata = {26'h0000000, q.data[13:8]};
					default: d.pslverr = 1'b1;
				endcase
			end
		end
		// completed transfer: register writes
		if (access) begin
			// a stalled strobe transfer is over once its access completes
			d.op = OP_NONE;
			if (apb_i.pwrite) begin
				case (apb_i.paddr)
					`PFAC_OFS_CTRL: begin
						// strobe and flag are owned by hardware here
						d.ctrl = apb_i.pwdata[7:0];
						d.ctrl[`PFAC_CTRL_WR] = q.busy ? 1'b1 : 1'b0;
						// flag cleared only by software; a stalled strobe keeps the set
						d.ctrl[`PFAC_CTRL_FLAG] = (q.op != OP_NONE) ? q.ctrl[`PFAC_CTRL_FLAG]
							: q.ctrl[`PFAC_CTRL_FLAG] & apb_i.pwdata[`PFAC_CTRL_FLAG];
						// read strobe only sets, hardware clears
						d.ctrl[`PFAC_CTRL_RD] = q.ctrl[`PFAC_CTRL_RD]
							| apb_i.pwdata[`PFAC_CTRL_RD];
					end
					`PFAC_OFS_ADRL: d.addr[7:0] = apb_i.pwdata[7:0];
					`PFAC_OFS_ADRH: d.addr[14:8] = apb_i.pwdata[6:0];
					// software may overwrite the data pair
					`PFAC_OFS_DATL: d.data[7:0] = apb_i.pwdata[7:0];
					`PFAC_OFS_DATH: d.data[13:8] = apb_i.pwdata[5:0];
					`PFAC_OFS_KEY: begin
						// key register itself stores nothing
					end
					default: begin
						// unmapped offsets were answered with an error at setup
					end
				endcase
			end
			// unlock sequence steps on completed transfers
			// 55h then AAh then strobe
			d.ul = UL_IDLE;
			if (apb_i.pwrite && apb_i.paddr == `PFAC_OFS_KEY) begin
				if (apb_i.pwdata[7:0] == `PFAC_KEY1) begin
					d.ul = UL_KEY1;
				end else if (apb_i.pwdata[7:0] == `PFAC_KEY2 && q.ul == UL_KEY1) begin
					d.ul = UL_KEY2;
				end
			end
		end
		// an idle cycle breaks the sequence
		if (q.ul != UL_IDLE && !apb_i.psel) begin
			d.ul = UL_IDLE;
		end
		if (q.ctrl[`PFAC_CTRL_RD]) begin
			d.data = rd_word;
			d.ctrl[`PFAC_CTRL_RD] = 1'b0;
		end
		// operation end: release the stalled write
		if (finish) begin
			d.busy = 1'b0;
			d.pready = 1'b1;
			d.ctrl[`PFAC_CTRL_WR] = 1'b0;
			case (q.op)
				OP_ERASE: begin
					if (q.ctrl[`PFAC_CTRL_SPACE]) begin
						for (int i = 0; i < UIDS; i++) begin
							d.uid[i] = `PFAC_ERASED;
						end
					end
					d.ctrl[`PFAC_CTRL_FLAG] = 1'b1;
				end
				OP_LOAD: begin
					d.latch[q.addr[LW-1:0]] = q.data;
				end
				OP_PROG: begin
					// only the latches burn; the data pair is not loaded into them first
					if (q.ctrl[`PFAC_CTRL_SPACE]) begin
						for (int i = 0; i < UIDS; i++) begin
							d.uid[i] = q.uid[i] & q.latch[i];
						end
					end
					for (int i = 0; i < ROW; i++) begin
						d.latch[i] = `PFAC_ERASED;
					end
					d.ctrl[`PFAC_CTRL_FLAG] = 1'b1;
				end
				default: begin
					// nothing was running
				end
			endcase
		end
		// cpu suspended while reading or operating
		d.stall = d.busy || d.ctrl[`PFAC_CTRL_RD];
		d.irq = d.ctrl[`PFAC_CTRL_FLAG] && d.ctrl[`PFAC_CTRL_IE];
	end

	// state register; only constants under reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q.ul <= UL_IDLE;
			q.op <= OP_NONE;
			q.busy <= 1'b0;
			q.cnt <= '0;
			q.ctrl <= `PFAC_CTRL_RST;
			q.addr <= '0;
			q.data <= '0;
			q.latch <= {ROW{`PFAC_ERASED}};
			q.uid <= {UIDS{`PFAC_ERASED}};
			q.pready <= 1'b0;
			q.pslverr <= 1'b0;
			q.prdata <= '0;
			q.ind_data <= '0;
			q.ind_valid <= 1'b0;
			q.stall <= 1'b0;
			q.irq <= 1'b0;
		end else begin
			q <= d;
		end
	end

	// outputs straight from the state flops
	assign apb_o.pready = q.pready;
	assign apb_o.pslverr = q.pslverr;
	assign apb_o.prdata = q.prdata;
	assign ind_data_o = q.ind_data;
	assign ind_valid_o = q.ind_valid;
	assign cpu_stall_o = q.stall;
	assign done_irq_o = q.irq;
endmodule // pfac_top
`default_nettype wire

// file: dv/pfac_top_checker.sv
// port checker for the flash access control block
`timescale 1ns/10ps
`default_nettype none
module pfac_top_checker import pfac_pkg::*; (
	input wire logic pclk, // clock
	input wire logic presetn, // reset, active low
	input wire pfac_apb_req_t apb_i, // apb request
	input wire pfac_apb_rsp_t apb_o, // apb answer
	input wire pfac_ind_req_t ind_i, // indirect request
	input wire logic [7:0] ind_data_o, // indirect byte
	input wire logic ind_valid_o, // indirect byte valid
	input wire logic write_protect, // protection level
	input wire logic cpu_stall_o, // cpu suspended
	input wire logic done_irq_o // completion interrupt
);
	logic setup; // setup cycle of any transfer
	logic strobe; // control write that sets the write strobe
	assign setup = apb_i.psel && !apb_i.penable;
	assign strobe = setup && apb_i.pwrite && apb_i.paddr == 12'h000 && apb_i.pwdata[1];
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	ready_one_cycle_a: assert property (apb_o.pready |=> !apb_o.pready)
		else $error("pready stood longer than one cycle");
	error_with_ready_a: assert property (apb_o.pslverr |-> apb_o.pready)
		else $error("pslverr without pready");
	plain_answer_a: assert property (setup && !strobe |=> apb_o.pready)
		else $error("plain transfer not answered next cycle");
	stall_busy_a: assert property (apb_i.psel && apb_i.penable && !apb_o.pready
		|-> cpu_stall_o)
		else $error("waiting access without cpu stall");
	protect_refuse_a: assert property (strobe && write_protect && !apb_i.pwdata[0]
		|=> apb_o.pready && !cpu_stall_o)
		else $error("protected strobe started an operation");
	ind_answer_a: assert property (ind_i.valid |=> ind_valid_o)
		else $error("indirect byte late");
	ind_quiet_a: assert property (!ind_i.valid |=> !ind_valid_o)
		else $error("indirect valid without request");
	ind_window_a: assert property (ind_i.valid && !ind_i.addr[15]
		|=> ind_data_o == 8'h00)
		else $error("byte outside the flash window");
	cover property (strobe && !write_protect);
	cover property (apb_o.pslverr);
	cover property (done_irq_o);
endmodule // pfac_top_checker
bind pfac_top pfac_top_checker i_chk (.pclk(pclk), .presetn(presetn), .apb_i(apb_i),
	.apb_o(apb_o), .ind_i(ind_i), .ind_data_o(ind_data_o), .ind_valid_o(ind_valid_o),
	.write_protect(write_protect), .cpu_stall_o(cpu_stall_o), .done_irq_o(done_irq_o));
`default_nettype wire

// file: dv/pfac_cpu_model.sv
// cpu side model: firmware register accesses over apb
`timescale 1ns/10ps
`default_nettype none
module pfac_cpu_model import pfac_pkg::*; (
	input wire logic pclk, // clock
	input wire pfac_apb_rsp_t apb_o, // answer from the block
	output var pfac_apb_req_t apb_i // request to the block
);
	logic global_irq_enable; // modelled global_irq_enable
	initial begin
		apb_i = '0;
		global_irq_enable = 1'b1;
	end
	// one transfer; last drops psel, otherwise the next setup follows at once
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		input bit last, output logic [31:0] q);
		apb_i.psel <= 1'b1;
		apb_i.penable <= 1'b0;
		apb_i.pwrite <= w;
		apb_i.paddr <= a;
		apb_i.pwdata <= d;
		@(posedge pclk);
		apb_i.penable <= 1'b1;
		// wait for the answer; only the bench watchdog ends a hang
		do begin
			@(posedge pclk);
		end while (apb_o.pready !== 1'b1);
		q = apb_o.prdata;
		// a following setup lowers penable itself, so it is driven once
		if (last) begin
			apb_i.penable <= 1'b0;
			apb_i.psel <= 1'b0;
			@(posedge pclk);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(1'b1, a, d, 1'b1, q);
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] q);
		xfer(1'b0, a, 32'h0, 1'b1, q);
	endtask
	// keys back to back; gap inserts an idle cycle
	task automatic unlock(input logic [31:0] ctrl, input bit gap);
		logic [31:0] q;
		global_irq_enable = 1'b0;
		xfer(1'b1, 12'h004, 32'h55, 1'b0, q);
		xfer(1'b1, 12'h004, 32'haa, gap, q);
		xfer(1'b1, 12'h000, ctrl, 1'b1, q);
		global_irq_enable = 1'b1;
	endtask
endmodule // pfac_cpu_model
`default_nettype wire

// file: dv/test_program_flash_access_control.sv
// self-checking bench for the flash access control block
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin errors++; \
	$display("wrong value %s exp %h got %h", n, e, s); end end
module test_program_flash_access_control import pfac_pkg::*;;
	localparam logic [13:0] DEV = 14'h1a5c; // arbitrary value
	logic pclk = 1'b0; // bench clock
	logic presetn, wp, ind_valid, stall, irq; // bench signals
	pfac_apb_req_t apb_i; // request from the model
	pfac_apb_rsp_t apb_o; // answer of the block
	pfac_ind_req_t ind; // indirect request
	logic [7:0] ind_data; // indirect byte
	logic [31:0] q, seed; // read data and random seed
	logic [10:0] adr; // random flash word address
	logic [13:0] dat; // random word
	logic [7:0] tbl [3][3]; // refusal cases: pre ctrl, strobe ctrl, gap/protect
	int errors, cmp_count;
	pfac_top #(.ERASE_CYCLES(3), .PROG_CYCLES(3), .DEV_ID(DEV)) i_dut (.pclk(pclk),
		.presetn(presetn), .apb_i(apb_i), .apb_o(apb_o), .ind_i(ind),
		.ind_data_o(ind_data), .ind_valid_o(ind_valid), .write_protect(wp),
		.cpu_stall_o(stall), .done_irq_o(irq));
	pfac_cpu_model i_cpu (.pclk(pclk), .apb_o(apb_o), .apb_i(apb_i));
	always #20 pclk = ~pclk;
	// expected data pair halves of a word
	function automatic logic [31:0] lo(input logic [13:0] w);
		return {24'h0, w[7:0]};
	endfunction
	function automatic logic [31:0] hi(input logic [13:0] w);
		return {26'h0, w[13:8]};
	endfunction
	task automatic summarize;
		$display("comparisons %0d errors %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// read strobe in space sp, then both data halves
	task automatic rdword(input logic sp, input logic [13:0] e);
		i_cpu.wr(12'h000, {26'h0, sp, 5'h01});
		i_cpu.rd(12'h010, q);
		`CHK("data low", lo(e), q)
		i_cpu.rd(12'h014, q);
		`CHK("data high", hi(e), q)
	endtask
	// indirect read, byte checked half a cycle after it lands
	task automatic ind_rd(input logic [15:0] a, input logic [7:0] e);
		ind <= '{1'b1, a};
		@(posedge pclk);
		ind <= '0;
		@(negedge pclk);
		`CHK("ind valid", 1'b1, ind_valid)
		`CHK("ind byte", e, ind_data)
		@(posedge pclk);
	endtask
	initial begin
		#(40 * 5000);
		errors++;
		summarize();
	end
	initial begin
		presetn = 0; wp = 0; ind = '0; errors = 0; cmp_count = 0;
		seed = 32'h96409f74;
		tbl = '{'{8'h0c, 8'h0e, 8'h01}, '{8'h08, 8'h0a, 8'h00}, '{8'h0c, 8'h0e, 8'h02}};
		adr = $random(seed);
		dat = $random(seed);
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		i_cpu.rd(12'h000, q);
		`CHK("ctrl reset", 32'h0, q)
		i_cpu.rd(12'h004, q);
		`CHK("key read", 32'h0, q)
		i_cpu.rd(12'h018, q);
		i_cpu.wr(12'h008, {24'h0, adr[7:0]});
		i_cpu.wr(12'h00c, {29'h0, adr[10:8]});
		// row erase with completion interrupt enabled
		i_cpu.wr(12'h000, 32'h8c);
		i_cpu.unlock(32'h8e, 1'b0);
		i_cpu.rd(12'h000, q);
		`CHK("ctrl after erase", 32'hcc, q)
		`CHK("irq", 1'b1, irq)
		i_cpu.wr(12'h000, 32'h0c);
		`CHK("irq cleared", 1'b0, irq)
		rdword(1'b0, 14'h3fff);
		// row erased above, so one latch then program suffices
		i_cpu.wr(12'h010, lo(dat));
		i_cpu.wr(12'h014, hi(dat));
		i_cpu.wr(12'h000, 32'h14);
		i_cpu.unlock(32'h16, 1'b0);
		i_cpu.wr(12'h000, 32'h04);
		i_cpu.unlock(32'h06, 1'b0);
		rdword(1'b0, dat);
		ind_rd({5'b10000, adr}, dat[7:0]);
		ind_rd({5'b00000, adr}, 8'h00);
		// refused strobes: gap, no write enable, protected
		for (int i = 0; i < 3; i++) begin
			wp <= tbl[i][2][1];
			i_cpu.wr(12'h000, {24'h0, tbl[i][0]});
			i_cpu.unlock({24'h0, tbl[i][1]}, tbl[i][2][0]);
			i_cpu.rd(12'h000, q);
			`CHK("ctrl refused", {24'h0, tbl[i][0]}, q)
			rdword(1'b0, dat);
		end
		wp <= 1'b0;
		i_cpu.wr(12'h010, 32'h5a);
		i_cpu.rd(12'h010, q);
		`CHK("data kept", 32'h5a, q)
		i_cpu.wr(12'h008, 32'h06);
		i_cpu.wr(12'h00c, 32'h00);
		rdword(1'b1, DEV);
		summarize();
	end
endmodule // test_program_flash_access_control
`default_nettype wire
